// ---- core/dmbo_pkg.sv ----
// Package of constants and types for the data move and bit operation decoder
package dmbo_pkg;

   // ----------------------------------------
   // Encoded lengths and machine-cycle counts
   // ----------------------------------------
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [1:0] CYC_1 = 2'h1;
   localparam logic [1:0] CYC_2 = 2'h2;

   // ----------------------------------------
   // Address space boundaries
   // ----------------------------------------
   localparam logic [7:0] SFR_BASE    = 8'h80;
   localparam int         ADDR_W_DEF  = 16;
   localparam int         DATA_W      = 8;

   // ----------------------------------------
   // Opcode patterns (casez, ? marks a don't care)
   // ----------------------------------------
   localparam logic [7:0] OP_A_WREG     = 8'b1110_1???;
   localparam logic [7:0] OP_A_DIR      = 8'b1110_0101;
   localparam logic [7:0] OP_A_IND      = 8'b1110_011?;
   localparam logic [7:0] OP_A_IMM      = 8'b0111_0100;
   localparam logic [7:0] OP_WREG_A     = 8'b1111_1???;
   localparam logic [7:0] OP_WREG_DIR   = 8'b1010_1???;
   localparam logic [7:0] OP_WREG_IMM   = 8'b0111_1???;
   localparam logic [7:0] OP_DIR_A      = 8'b1111_0101;
   localparam logic [7:0] OP_DIR_WREG   = 8'b1000_1???;
   localparam logic [7:0] OP_DIR_DIR    = 8'b1000_0101;
   localparam logic [7:0] OP_DIR_IND    = 8'b1000_011?;
   localparam logic [7:0] OP_DIR_IMM    = 8'b0111_0101;
   localparam logic [7:0] OP_IND_A      = 8'b1111_011?;
   localparam logic [7:0] OP_IND_DIR    = 8'b1010_011?;
   localparam logic [7:0] OP_IND_IMM    = 8'b0111_011?;
   localparam logic [7:0] OP_PTR_IMM    = 8'b1001_0000;
   localparam logic [7:0] OP_CODE_PTR   = 8'b1001_0011;
   localparam logic [7:0] OP_CODE_PC    = 8'b1000_0011;
   localparam logic [7:0] OP_XRD_IND    = 8'b1110_001?;
   localparam logic [7:0] OP_XRD_PTR    = 8'b1110_0000;
   localparam logic [7:0] OP_XWR_IND    = 8'b1111_001?;
   localparam logic [7:0] OP_XWR_PTR    = 8'b1111_0000;
   localparam logic [7:0] OP_PUSH       = 8'b1100_0000;
   localparam logic [7:0] OP_POP        = 8'b1101_0000;
   localparam logic [7:0] OP_SWP_WREG   = 8'b1100_1???;
   localparam logic [7:0] OP_SWP_DIR    = 8'b1100_0101;
   localparam logic [7:0] OP_SWP_IND    = 8'b1100_011?;
   localparam logic [7:0] OP_NIB_IND    = 8'b1101_011?;
   localparam logic [7:0] OP_CLR_C      = 8'b1100_0011;
   localparam logic [7:0] OP_CLR_BIT    = 8'b1100_0010;
   localparam logic [7:0] OP_SET_C      = 8'b1101_0011;
   localparam logic [7:0] OP_SET_BIT    = 8'b1101_0010;
   localparam logic [7:0] OP_CPL_C      = 8'b1011_0011;
   localparam logic [7:0] OP_CPL_BIT    = 8'b1011_0010;
   localparam logic [7:0] OP_AND_C_BIT  = 8'b1000_0010;
   localparam logic [7:0] OP_AND_C_NBIT = 8'b1011_0000;
   localparam logic [7:0] OP_OR_C_BIT   = 8'b0111_0010;
   localparam logic [7:0] OP_OR_C_NBIT  = 8'b1010_0000;
   localparam logic [7:0] OP_C_BIT      = 8'b1010_0010;
   localparam logic [7:0] OP_BIT_C      = 8'b1001_0010;
   localparam logic [7:0] OP_BR_C       = 8'b0100_0000;
   localparam logic [7:0] OP_BR_NC      = 8'b0101_0000;
   localparam logic [7:0] OP_BR_B       = 8'b0010_0000;
   localparam logic [7:0] OP_BR_NB      = 8'b0011_0000;
   localparam logic [7:0] OP_BR_JBC     = 8'b0001_0000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [4:0] {
      CL_NONE, CL_MOVE, CL_CODE_LOAD, CL_EXT_MOVE, CL_PUSH, CL_POP, CL_SWAP, CL_NIBBLE_SWAP,
      CL_CLEAR, CL_SET, CL_COMPL, CL_AND, CL_AND_NOT, CL_OR, CL_OR_NOT, CL_BIT_TO_C,
      CL_C_TO_BIT, CL_BR_C, CL_BR_NC, CL_BR_B, CL_BR_NB, CL_BR_JBC
   } dmbo_class_t;

   typedef enum logic [3:0] {
      K_NONE, K_ACCUM, K_WREG, K_DIRECT, K_INDIRECT, K_IMM, K_IMM16, K_PTR,
      K_CODE_PTR, K_CODE_PC, K_EXTERNAL_DATA_SPACE_IND, K_EXTERNAL_DATA_SPACE_PTR, K_STACK, K_CARRY, K_BIT
   } dmbo_kind_t;

   typedef struct packed {
      logic        known;
      logic [1:0]  len;
      logic [1:0]  cycles;
      dmbo_class_t cls;
      dmbo_kind_t  src;
      dmbo_kind_t  dst;
   } dmbo_decode_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_FIRST = 2'h1,
      ST_LAST  = 2'h3
   } dmbo_state_t;

   localparam dmbo_decode_t DEC_RESET = '{1'b0, 2'h0, 2'h0, CL_NONE, K_NONE, K_NONE};

endpackage

// ---- core/dmbo_decoder.sv ----
// Decoder and sequencer for the data move and Boolean bit instruction groups
`timescale 1ns/100ps

// Overview of operation
// RULE1: accumulator loads take one cycle
// RULE2: direct into working register, 2 bytes/2 cycles
// RULE3: working register into direct, 2 bytes/2 cycles
// RULE4: direct to direct, 3 bytes/2 cycles
// RULE5: indirect into direct, 2 bytes/2 cycles
// RULE6: immediate into direct, 3 bytes/2 cycles
// RULE7: immediate through indirect pointer, 2 bytes/1 cycle
// RULE8: direct to indirect 2/2; accumulator 1/1
// RULE9: load 16-bit pointer, 3 bytes/2 cycles
// RULE10: code byte loads, 1 byte/2 cycles
// RULE11: external data moves, 1 byte/2 cycles
// RULE12: stack push and pop, 2 bytes/2 cycles
// RULE13: swaps take one cycle; direct form two bytes
// RULE14: carry AND/OR with bit, 2/2
// RULE15: bit to carry 1 cycle; back 2
// RULE16: branch on carry state, 2 bytes/2 cycles
// RULE17: branch on bit state, 3 bytes/2 cycles
// RULE18: clear/set/complement carry or bit, one cycle
// RULE19: jump-and-clear clears bit indivisibly with test
// RULE20: direct below 80h is memory, above special
// RULE21: relative offset is signed, added to counter
module dmbo_decoder #(
   parameter int ADDR_W = dmbo_pkg::ADDR_W_DEF
) (
   input  wire logic                 ref_clk,
   input  wire logic                 srst,
   input  wire logic                 issue_valid,
   input  wire logic [7:0]           opcode,
   input  wire logic [7:0]           direct_addr,
   input  wire logic [7:0]           rel_offset,
   input  wire logic [ADDR_W-1:0]    pc_next,
   input  wire logic                 carry_flag,
   input  wire logic                 tested_bit,
   output logic                      issue_ready,
   output dmbo_pkg::dmbo_decode_t    decoded,
   output logic                      exec_busy,
   output logic                      exec_last,
   output logic                      direct_is_sfr,
   output logic                      ind_reg_sel,
   output logic                      carry_write,
   output logic                      carry_result,
   output logic                      bit_write,
   output logic                      bit_result,
   output logic                      bit_lock,
   output logic                      branch_taken,
   output logic [ADDR_W-1:0]         branch_target
);

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (ADDR_W < 8 || ADDR_W > 32)
   begin : g_bad_width
      $error("dmbo_decoder: ADDR_W must lie between 8 and 32");
   end

   // ----------------------------------------
   // Opcode table
   // ----------------------------------------
   function automatic dmbo_pkg::dmbo_decode_t mk(
      input logic [1:0]            len,
      input logic [1:0]            cyc,
      input dmbo_pkg::dmbo_class_t cls,
      input dmbo_pkg::dmbo_kind_t  src,
      input dmbo_pkg::dmbo_kind_t  dst
   );
      mk = '{1'b1, len, cyc, cls, src, dst};
   endfunction

   function automatic dmbo_pkg::dmbo_decode_t decode(input logic [7:0] op);
      import dmbo_pkg::*;
      dmbo_decode_t d;
      d = DEC_RESET;
      casez (op)
         OP_A_WREG     : d = mk(LEN_1, CYC_1, CL_MOVE, K_WREG, K_ACCUM);            // [RULE1]
         OP_A_DIR      : d = mk(LEN_2, CYC_1, CL_MOVE, K_DIRECT, K_ACCUM);          // [RULE1]
         OP_A_IND      : d = mk(LEN_1, CYC_1, CL_MOVE, K_INDIRECT, K_ACCUM);        // [RULE1]
         OP_A_IMM      : d = mk(LEN_2, CYC_1, CL_MOVE, K_IMM, K_ACCUM);             // [RULE1]
         OP_WREG_A     : d = mk(LEN_1, CYC_1, CL_MOVE, K_ACCUM, K_WREG);
         OP_WREG_DIR   : d = mk(LEN_2, CYC_2, CL_MOVE, K_DIRECT, K_WREG);           // [RULE2]
         OP_WREG_IMM   : d = mk(LEN_2, CYC_1, CL_MOVE, K_IMM, K_WREG);
         OP_DIR_A      : d = mk(LEN_2, CYC_1, CL_MOVE, K_ACCUM, K_DIRECT);
         OP_DIR_WREG   : d = mk(LEN_2, CYC_2, CL_MOVE, K_WREG, K_DIRECT);           // [RULE3]
         OP_DIR_DIR    : d = mk(LEN_3, CYC_2, CL_MOVE, K_DIRECT, K_DIRECT);         // [RULE4]
         OP_DIR_IND    : d = mk(LEN_2, CYC_2, CL_MOVE, K_INDIRECT, K_DIRECT);       // [RULE5]
         OP_DIR_IMM    : d = mk(LEN_3, CYC_2, CL_MOVE, K_IMM, K_DIRECT);            // [RULE6]
         OP_IND_A      : d = mk(LEN_1, CYC_1, CL_MOVE, K_ACCUM, K_INDIRECT);        // [RULE8]
         OP_IND_DIR    : d = mk(LEN_2, CYC_2, CL_MOVE, K_DIRECT, K_INDIRECT);       // [RULE8]
         OP_IND_IMM    : d = mk(LEN_2, CYC_1, CL_MOVE, K_IMM, K_INDIRECT);          // [RULE7]
         OP_PTR_IMM    : d = mk(LEN_3, CYC_2, CL_MOVE, K_IMM16, K_PTR);             // [RULE9]
         OP_CODE_PTR   : d = mk(LEN_1, CYC_2, CL_CODE_LOAD, K_CODE_PTR, K_ACCUM);   // [RULE10]
         OP_CODE_PC    : d = mk(LEN_1, CYC_2, CL_CODE_LOAD, K_CODE_PC, K_ACCUM);    // [RULE10]
         OP_XRD_IND    : d = mk(LEN_1, CYC_2, CL_EXT_MOVE, K_EXTERNAL_DATA_SPACE_IND, K_ACCUM);   // [RULE11]
         OP_XRD_PTR    : d = mk(LEN_1, CYC_2, CL_EXT_MOVE, K_EXTERNAL_DATA_SPACE_PTR, K_ACCUM);   // [RULE11]
         OP_XWR_IND    : d = mk(LEN_1, CYC_2, CL_EXT_MOVE, K_ACCUM, K_EXTERNAL_DATA_SPACE_IND);   // [RULE11]
         OP_XWR_PTR    : d = mk(LEN_1, CYC_2, CL_EXT_MOVE, K_ACCUM, K_EXTERNAL_DATA_SPACE_PTR);   // [RULE11]
         OP_PUSH       : d = mk(LEN_2, CYC_2, CL_PUSH, K_DIRECT, K_STACK);          // [RULE12]
         OP_POP        : d = mk(LEN_2, CYC_2, CL_POP, K_STACK, K_DIRECT);           // [RULE12]
         OP_SWP_WREG   : d = mk(LEN_1, CYC_1, CL_SWAP, K_WREG, K_ACCUM);            // [RULE13]
         OP_SWP_DIR    : d = mk(LEN_2, CYC_1, CL_SWAP, K_DIRECT, K_ACCUM);          // [RULE13]
         OP_SWP_IND    : d = mk(LEN_1, CYC_1, CL_SWAP, K_INDIRECT, K_ACCUM);        // [RULE13]
         OP_NIB_IND    : d = mk(LEN_1, CYC_1, CL_NIBBLE_SWAP, K_INDIRECT, K_ACCUM); // [RULE13]
         OP_CLR_C      : d = mk(LEN_1, CYC_1, CL_CLEAR, K_NONE, K_CARRY);           // [RULE18]
         OP_CLR_BIT    : d = mk(LEN_2, CYC_1, CL_CLEAR, K_NONE, K_BIT);             // [RULE18]
         OP_SET_C      : d = mk(LEN_1, CYC_1, CL_SET, K_NONE, K_CARRY);             // [RULE18]
         OP_SET_BIT    : d = mk(LEN_2, CYC_1, CL_SET, K_NONE, K_BIT);               // [RULE18]
         OP_CPL_C      : d = mk(LEN_1, CYC_1, CL_COMPL, K_CARRY, K_CARRY);          // [RULE18]
         OP_CPL_BIT    : d = mk(LEN_2, CYC_1, CL_COMPL, K_BIT, K_BIT);              // [RULE18]
         OP_AND_C_BIT  : d = mk(LEN_2, CYC_2, CL_AND, K_BIT, K_CARRY);              // [RULE14]
         OP_AND_C_NBIT : d = mk(LEN_2, CYC_2, CL_AND_NOT, K_BIT, K_CARRY);          // [RULE14]
         OP_OR_C_BIT   : d = mk(LEN_2, CYC_2, CL_OR, K_BIT, K_CARRY);               // [RULE14]
         OP_OR_C_NBIT  : d = mk(LEN_2, CYC_2, CL_OR_NOT, K_BIT, K_CARRY);           // [RULE14]
         OP_C_BIT      : d = mk(LEN_2, CYC_1, CL_BIT_TO_C, K_BIT, K_CARRY);         // [RULE15]
         OP_BIT_C      : d = mk(LEN_2, CYC_2, CL_C_TO_BIT, K_CARRY, K_BIT);         // [RULE15]
         OP_BR_C       : d = mk(LEN_2, CYC_2, CL_BR_C, K_CARRY, K_NONE);            // [RULE16]
         OP_BR_NC      : d = mk(LEN_2, CYC_2, CL_BR_NC, K_CARRY, K_NONE);           // [RULE16]
         OP_BR_B       : d = mk(LEN_3, CYC_2, CL_BR_B, K_BIT, K_NONE);              // [RULE17]
         OP_BR_NB      : d = mk(LEN_3, CYC_2, CL_BR_NB, K_BIT, K_NONE);             // [RULE17]
         OP_BR_JBC     : d = mk(LEN_3, CYC_2, CL_BR_JBC, K_BIT, K_BIT);             // [RULE17]
         default       : d = DEC_RESET;
      endcase
      return d;
   endfunction

   // ----------------------------------------
   // Decode and operand evaluation
   // ----------------------------------------
   dmbo_pkg::dmbo_decode_t dec_now;
   dmbo_pkg::dmbo_state_t  state;
   dmbo_pkg::dmbo_state_t  next_state;
   wire logic              accept;
   wire logic              two_cycle;
   wire logic              uses_direct;
   wire logic              uses_indirect;
   wire logic              next_carry_write;
   wire logic              next_carry_result;
   wire logic              next_bit_write;
   wire logic              next_bit_result;
   wire logic              next_taken;
   wire logic [ADDR_W-1:0] rel_ext;

   assign dec_now = decode(opcode);
   assign accept  = issue_valid && issue_ready;
   // Unknown opcodes are still taken, for one cycle, so the pipe never hangs
   assign two_cycle = dec_now.known && (dec_now.cycles == dmbo_pkg::CYC_2);

   assign uses_direct = (dec_now.src == dmbo_pkg::K_DIRECT) || (dec_now.dst == dmbo_pkg::K_DIRECT)
                        || (dec_now.src == dmbo_pkg::K_STACK) || (dec_now.dst == dmbo_pkg::K_STACK);
   assign uses_indirect = (dec_now.src == dmbo_pkg::K_INDIRECT) || (dec_now.dst == dmbo_pkg::K_INDIRECT)
                          || (dec_now.src == dmbo_pkg::K_EXTERNAL_DATA_SPACE_IND) || (dec_now.dst == dmbo_pkg::K_EXTERNAL_DATA_SPACE_IND);

   assign next_carry_write = (dec_now.dst == dmbo_pkg::K_CARRY);
   assign next_carry_result =
      (dec_now.cls == dmbo_pkg::CL_SET)      ? 1'b1 :
      (dec_now.cls == dmbo_pkg::CL_COMPL)    ? !carry_flag :
      (dec_now.cls == dmbo_pkg::CL_AND)      ? (carry_flag & tested_bit) :        // [RULE14]
      (dec_now.cls == dmbo_pkg::CL_AND_NOT)  ? (carry_flag & !tested_bit) :       // [RULE14]
      (dec_now.cls == dmbo_pkg::CL_OR)       ? (carry_flag | tested_bit) :        // [RULE14]
      (dec_now.cls == dmbo_pkg::CL_OR_NOT)   ? (carry_flag | !tested_bit) :       // [RULE14]
      (dec_now.cls == dmbo_pkg::CL_BIT_TO_C) ? tested_bit : 1'b0;                 // [RULE15]

   // Jump-and-clear writes the bit only when the test found it set
   assign next_bit_write = (dec_now.dst == dmbo_pkg::K_BIT)
                           && ((dec_now.cls != dmbo_pkg::CL_BR_JBC) || tested_bit);   // [RULE19]
   assign next_bit_result =
      (dec_now.cls == dmbo_pkg::CL_SET)      ? 1'b1 :                             // [RULE18]
      (dec_now.cls == dmbo_pkg::CL_COMPL)    ? !tested_bit :                      // [RULE18]
      (dec_now.cls == dmbo_pkg::CL_C_TO_BIT) ? carry_flag : 1'b0;                 // [RULE15]

   assign next_taken =
      ((dec_now.cls == dmbo_pkg::CL_BR_C)   &&  carry_flag) ||                    // [RULE16]
      ((dec_now.cls == dmbo_pkg::CL_BR_NC)  && !carry_flag) ||                    // [RULE16]
      ((dec_now.cls == dmbo_pkg::CL_BR_B)   &&  tested_bit) ||                    // [RULE17]
      ((dec_now.cls == dmbo_pkg::CL_BR_NB)  && !tested_bit) ||                    // [RULE17]
      ((dec_now.cls == dmbo_pkg::CL_BR_JBC) &&  tested_bit);                      // [RULE17]

   // Sign extension keeps backward branches wrapping inside the code space
   assign rel_ext = {{(ADDR_W-8){rel_offset[7]}}, rel_offset};                    // [RULE21]

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         dmbo_pkg::ST_IDLE,
         dmbo_pkg::ST_LAST:
         begin
            if (accept)
               next_state = two_cycle ? dmbo_pkg::ST_FIRST : dmbo_pkg::ST_LAST;
            else
               next_state = dmbo_pkg::ST_IDLE;
         end
         dmbo_pkg::ST_FIRST:
            next_state = dmbo_pkg::ST_LAST;
         default:
            next_state = dmbo_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state       <= dmbo_pkg::ST_IDLE;
         issue_ready <= 1'b1;
         exec_busy   <= 1'b0;
         exec_last   <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         issue_ready <= (next_state != dmbo_pkg::ST_FIRST);
         exec_busy   <= (next_state != dmbo_pkg::ST_IDLE);
         exec_last   <= (next_state == dmbo_pkg::ST_LAST);
      end
   end

   // ----------------------------------------
   // Captured results, held for the whole instruction
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         decoded       <= dmbo_pkg::DEC_RESET;
         direct_is_sfr <= 1'b0;
         ind_reg_sel   <= 1'b0;
         carry_write   <= 1'b0;
         carry_result  <= 1'b0;
         bit_write     <= 1'b0;
         bit_result    <= 1'b0;
         bit_lock      <= 1'b0;
         branch_taken  <= 1'b0;
         branch_target <= '0;
      end
      else if (accept)
      begin
         decoded       <= dec_now;
         direct_is_sfr <= uses_direct && (direct_addr >= dmbo_pkg::SFR_BASE);    // [RULE20]
         ind_reg_sel   <= uses_indirect && opcode[0];                            // [RULE20]
         carry_write   <= next_carry_write;
         carry_result  <= next_carry_result;
         bit_write     <= next_bit_write;
         bit_result    <= next_bit_result;
         // Held over both cycles so no other access reaches the tested bit
         bit_lock      <= (dec_now.cls == dmbo_pkg::CL_BR_JBC);                  // [RULE19]
         branch_taken  <= next_taken;
         branch_target <= ADDR_W'(pc_next + rel_ext);                            // [RULE21]
      end
      else if (next_state == dmbo_pkg::ST_IDLE)
      begin
         bit_lock      <= 1'b0;
         carry_write   <= 1'b0;
         bit_write     <= 1'b0;
         branch_taken  <= 1'b0;
      end
   end

endmodule

// ---- testbench/dmbo_decoder_asserts.sv ----
// Port checks for the data move and bit operation decoder
`timescale 1ns/100ps

module dmbo_decoder_checker #(
   parameter int ADDR_W = dmbo_pkg::ADDR_W_DEF
) (
   input wire logic                   ref_clk,
   input wire logic                   srst,
   input wire logic                   issue_valid,
   input wire logic [7:0]             direct_addr,
   input wire logic [7:0]             rel_offset,
   input wire logic [ADDR_W-1:0]      pc_next,
   input wire logic                   carry_flag,
   input wire logic                   tested_bit,
   input wire logic                   issue_ready,
   input wire dmbo_pkg::dmbo_decode_t decoded,
   input wire logic                   exec_busy,
   input wire logic                   exec_last,
   input wire logic                   direct_is_sfr,
   input wire logic                   carry_write,
   input wire logic                   carry_result,
   input wire logic                   bit_write,
   input wire logic                   bit_lock,
   input wire logic                   branch_taken,
   input wire logic [ADDR_W-1:0]      branch_target
);
   // ----------------------------------------
   // Accept strobe, sign extension, properties
   // ----------------------------------------
   wire logic              acc = issue_valid && issue_ready;
   wire logic [ADDR_W-1:0] rel_ext = {{(ADDR_W - 8){rel_offset[7]}}, rel_offset};

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   property p_busy;
      acc |=> exec_busy;
   endproperty
   a_busy: assert property (p_busy) else $error("not started");
   property p_one;
      acc ##1 (decoded.cycles == dmbo_pkg::CYC_1) |-> exec_last && issue_ready;
   endproperty
   a_one: assert property (p_one) else $error("one-cycle timing");
   property p_two;
      acc ##1 (decoded.cycles == dmbo_pkg::CYC_2) |-> !issue_ready && !exec_last ##1 exec_last && issue_ready;
   endproperty
   a_two: assert property (p_two) else $error("two-cycle timing");
   property p_idle;
      exec_last && !acc |=> !exec_busy;
   endproperty
   a_idle: assert property (p_idle) else $error("busy after last cycle");
   property p_target;
      acc ##1 (decoded.cls >= dmbo_pkg::CL_BR_C) |-> branch_target == $past(pc_next) + $past(rel_ext);
   endproperty
   a_target: assert property (p_target) else $error("branch target wrong");
   property p_sfr;
      acc ##1 (decoded.cls inside {dmbo_pkg::CL_PUSH, dmbo_pkg::CL_POP})
         |-> direct_is_sfr == $past(direct_addr[7]);
   endproperty
   a_sfr: assert property (p_sfr) else $error("space split");
   property p_nowr;
      exec_busy && !decoded.known |-> !carry_write && !bit_write && !branch_taken;
   endproperty
   a_nowr: assert property (p_nowr) else $error("unknown wrote");
   property p_and;
      acc ##1 (decoded.cls == dmbo_pkg::CL_AND)
         |-> carry_write && carry_result == ($past(carry_flag) && $past(tested_bit));
   endproperty
   a_and: assert property (p_and) else $error("carry AND");
   property p_brc;
      acc ##1 (decoded.cls == dmbo_pkg::CL_BR_C) |-> branch_taken == $past(carry_flag);
   endproperty
   a_brc: assert property (p_brc) else $error("carry branch");
   property p_jbc;
      acc ##1 (decoded.cls == dmbo_pkg::CL_BR_JBC)
         |-> bit_lock && bit_write == $past(tested_bit) && branch_taken == $past(tested_bit) ##1 bit_lock;
   endproperty
   a_jbc: assert property (p_jbc) else $error("clear-jump lock");
endmodule

bind dmbo_decoder dmbo_decoder_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- testbench/data_move_and_bit_op_timing_tb_top.sv ----
// Self-checking bench for the data move and bit operation decoder
`timescale 1ns/100ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("mismatch at %0t: %s", $time, m); end end

module data_move_and_bit_op_timing_tb_top;
   localparam int AW = 16;
   logic                   ref_clk, srst, issue_valid, carry_flag, tested_bit;
   logic [7:0]             opcode, direct_addr, rel_offset;
   logic [AW-1:0]          pc_next, branch_target;
   logic                   issue_ready, exec_busy, exec_last, direct_is_sfr, ind_reg_sel;
   logic                   carry_write, carry_result, bit_write, bit_result, bit_lock, branch_taken;
   dmbo_pkg::dmbo_decode_t decoded;
   int                     num_errors = 0;
   int                     total_checks = 0;

   dmbo_decoder #(.ADDR_W(AW)) u_dut (
      .ref_clk(ref_clk), .srst(srst), .issue_valid(issue_valid), .opcode(opcode), .direct_addr(direct_addr),
      .rel_offset(rel_offset), .pc_next(pc_next), .carry_flag(carry_flag), .tested_bit(tested_bit),
      .issue_ready(issue_ready), .decoded(decoded), .exec_busy(exec_busy), .exec_last(exec_last),
      .direct_is_sfr(direct_is_sfr), .ind_reg_sel(ind_reg_sel), .carry_write(carry_write),
      .carry_result(carry_result), .bit_write(bit_write), .bit_result(bit_result), .bit_lock(bit_lock),
      .branch_taken(branch_taken), .branch_target(branch_target)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [4:0] exp_lc(input logic [7:0] op);
      casez (op)
         dmbo_pkg::OP_A_WREG, dmbo_pkg::OP_A_IND, dmbo_pkg::OP_WREG_A, dmbo_pkg::OP_IND_A, dmbo_pkg::OP_SWP_WREG,
         dmbo_pkg::OP_SWP_IND, dmbo_pkg::OP_NIB_IND, dmbo_pkg::OP_CLR_C, dmbo_pkg::OP_SET_C,
         dmbo_pkg::OP_CPL_C: return 5'h15;
         dmbo_pkg::OP_A_DIR, dmbo_pkg::OP_A_IMM, dmbo_pkg::OP_WREG_IMM, dmbo_pkg::OP_DIR_A, dmbo_pkg::OP_IND_IMM,
         dmbo_pkg::OP_SWP_DIR, dmbo_pkg::OP_CLR_BIT, dmbo_pkg::OP_SET_BIT, dmbo_pkg::OP_CPL_BIT,
         dmbo_pkg::OP_C_BIT: return 5'h19;
         dmbo_pkg::OP_WREG_DIR, dmbo_pkg::OP_DIR_WREG, dmbo_pkg::OP_DIR_IND, dmbo_pkg::OP_IND_DIR, dmbo_pkg::OP_PUSH,
         dmbo_pkg::OP_POP, dmbo_pkg::OP_AND_C_BIT, dmbo_pkg::OP_AND_C_NBIT, dmbo_pkg::OP_OR_C_BIT,
         dmbo_pkg::OP_OR_C_NBIT, dmbo_pkg::OP_BIT_C, dmbo_pkg::OP_BR_C, dmbo_pkg::OP_BR_NC: return 5'h1A;
         dmbo_pkg::OP_DIR_DIR, dmbo_pkg::OP_DIR_IMM, dmbo_pkg::OP_PTR_IMM, dmbo_pkg::OP_BR_B, dmbo_pkg::OP_BR_NB,
         dmbo_pkg::OP_BR_JBC: return 5'h1E;
         dmbo_pkg::OP_CODE_PTR, dmbo_pkg::OP_CODE_PC, dmbo_pkg::OP_XRD_IND, dmbo_pkg::OP_XRD_PTR,
         dmbo_pkg::OP_XWR_IND, dmbo_pkg::OP_XWR_PTR: return 5'h16;
         default: return 5'h01;
      endcase
   endfunction

   function automatic logic [4:0] exp_fx(input logic [7:0] op, input logic c, input logic b);
      case (op)
         dmbo_pkg::OP_CLR_C: return 5'h10;
         dmbo_pkg::OP_SET_C: return 5'h18;
         dmbo_pkg::OP_CPL_C: return {1'b1, ~c, 3'h0};
         dmbo_pkg::OP_CLR_BIT: return 5'h04;
         dmbo_pkg::OP_SET_BIT: return 5'h06;
         dmbo_pkg::OP_CPL_BIT: return {3'h1, ~b, 1'b0};
         dmbo_pkg::OP_AND_C_BIT: return {1'b1, c & b, 3'h0};
         dmbo_pkg::OP_AND_C_NBIT: return {1'b1, c & ~b, 3'h0};
         dmbo_pkg::OP_OR_C_BIT: return {1'b1, c | b, 3'h0};
         dmbo_pkg::OP_OR_C_NBIT: return {1'b1, c | ~b, 3'h0};
         dmbo_pkg::OP_C_BIT: return {1'b1, b, 3'h0};
         dmbo_pkg::OP_BIT_C: return {3'h1, c, 1'b0};
         dmbo_pkg::OP_BR_C: return {4'h0, c};
         dmbo_pkg::OP_BR_NC: return {4'h0, ~c};
         dmbo_pkg::OP_BR_B: return {4'h0, b};
         dmbo_pkg::OP_BR_NB: return {4'h0, ~b};
         dmbo_pkg::OP_BR_JBC: return {2'h0, b, 1'b0, b};
         default: return 5'h00;
      endcase
   endfunction

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One instruction, to its last cycle; valid stays up between calls
   task automatic run_op(input logic [7:0] op, da, ro, input logic [AW-1:0] pc, input logic c, b);
      logic [4:0] lc, fx;
      int         n;
      lc = exp_lc(op);
      fx = exp_fx(op, c, b);
      {opcode, direct_addr, rel_offset, pc_next, carry_flag, tested_bit, issue_valid} = {op, da, ro, pc, c, b, 1'b1};
      for (n = 0; issue_ready !== 1'b1 && n < 8; n++) @(posedge ref_clk) #1;
      if (n == 8)
      begin
         num_errors++;
         finish_test();
      end
      @(posedge ref_clk) #1;
      `CHK(decoded.known, lc[4], "known")
      if (lc[4]) `CHK(decoded.len, lc[3:2], "length")
      `CHK(decoded.cycles, lc[4] ? lc[1:0] : 2'h0, "cycles")
      `CHK(issue_ready, lc[1:0] == dmbo_pkg::CYC_1, "ready")
      `CHK(carry_write, fx[4], "carry write")
      if (fx[4]) `CHK(carry_result, fx[3], "carry value")
      `CHK(bit_write, fx[2], "bit write")
      if (fx[2]) `CHK(bit_result, fx[1], "bit value")
      `CHK(branch_taken, fx[0], "taken")
      if (op ==? 8'b00?1_0000 || op ==? 8'b010?_0000 || op == 8'h20)
         `CHK(branch_target, pc + {{(AW - 8){ro[7]}}, ro}, "target")
      if (lc[4] && op[3:1] == 3'h3) `CHK(ind_reg_sel, op[0], "pointer")
      if (op == dmbo_pkg::OP_A_DIR || op == dmbo_pkg::OP_PUSH) `CHK(direct_is_sfr, da[7], "space")
      for (n = 1; exec_last !== 1'b1 && n < 4; n++) @(posedge ref_clk) #1;
      `CHK(n[1:0], lc[1:0], "last cycle")
   endtask

   initial
   begin
      {srst, issue_valid, carry_flag, tested_bit, opcode, direct_addr, rel_offset, pc_next} = {4'h8, 40'h00_0000_0000};
      void'($urandom(34));
      repeat (12) @(posedge ref_clk);
      #1 srst = 1'b0;
      // Every code once, unknown ones too
      for (int i = 0; i < 256; i++)
         run_op(i[7:0], 8'($urandom), 8'($urandom), 16'($urandom), i[0], i[1]);
      $display("test opcode_sweep done");
      // Space split, wrapping offsets
      run_op(dmbo_pkg::OP_A_DIR, 8'h7F, 8'h00, 16'h0000, 1'b0, 1'b0);
      run_op(dmbo_pkg::OP_PUSH, 8'h80, 8'h00, 16'h0000, 1'b0, 1'b0);
      run_op(dmbo_pkg::OP_BR_C, 8'h00, 8'h80, 16'h0000, 1'b1, 1'b0);
      run_op(dmbo_pkg::OP_BR_NB, 8'h00, 8'h7F, 16'hFFFF, 1'b0, 1'b0);
      run_op(dmbo_pkg::OP_BR_JBC, 8'h20, 8'hFF, 16'h0001, 1'b0, 1'b1);
      run_op(dmbo_pkg::OP_BR_JBC, 8'h20, 8'h01, 16'h0001, 1'b1, 1'b0);
      $display("test corners done");
      // Reset mid instruction
      {opcode, issue_valid} = {dmbo_pkg::OP_DIR_DIR, 1'b1};
      @(posedge ref_clk) #1;
      {issue_valid, srst} = 2'h1;
      @(posedge ref_clk) #1;
      `CHK(exec_busy, 1'b0, "busy")
      `CHK(issue_ready, 1'b1, "ready")
      `CHK(decoded, dmbo_pkg::DEC_RESET, "decode")
      srst = 1'b0;
      $display("test mid_reset done");
      for (int i = 0; i < 400; i++)
         run_op(8'($urandom), 8'($urandom), 8'($urandom), 16'($urandom), 1'($urandom), 1'($urandom));
      $display("test random_stream done");
      finish_test();
   end
endmodule
